/* File: dv/qpf_prog_mem.sv */
// program memory model facing the fetch pipeline
`timescale 1ns/1ps
module qpf_prog_mem (
    // fetch address
    input  wire logic [12:0] addr_in,
    // program word
    output logic      [13:0] data_out
);
    // word derived from the address so every fetch can be traced back
    assign data_out = {1'b1, addr_in ^ 13'h0A5C};
endmodule : qpf_prog_mem

/* File: dv/tb.sv */
// self-checking bench for the fetch and execute sequencer
`timescale 1ns/1ps
module tb;
    logic        clk_in = 1'b0;
    logic        srst_in, branch_in, irq_in;
    logic [1:0]  mem_size_in;
    logic [12:0] branch_target_in, prog_addr_out, program_counter_out;
    logic [13:0] prog_data_in, instruction_latch_out;
    logic        ph1, ph2, ph3, ph4, exec_v, rd, wr;
    logic [3:0]  ph, prev_ph, exp_ph;
    logic [12:0] last, tgt, exp_addr, exp_pc;
    logic        flush;
    int          cyc, bad_count, n_checks, ticks, rel;
    qpf_core qpf_core_i (.clk_in(clk_in), .srst_in(srst_in),
        .mem_size_in(mem_size_in), .prog_data_in(prog_data_in),
        .prog_addr_out(prog_addr_out), .branch_in(branch_in),
        .branch_target_in(branch_target_in), .irq_in(irq_in),
        .phase_one_clock_out(ph1), .phase_two_clock_out(ph2),
        .phase_three_clock_out(ph3), .phase_four_clock_out(ph4),
        .instruction_latch_out(instruction_latch_out),
        .exec_valid_out(exec_v), .data_read_out(rd), .data_write_out(wr),
        .program_counter_out(program_counter_out));
    qpf_prog_mem qpf_prog_mem_i (.addr_in(prog_addr_out),
        .data_out(prog_data_in));
    ////////////////////////////////////////////////////////////////////////
    always #50 clk_in = ~clk_in;
    function automatic logic [12:0] mask(input logic [12:0] a);
        case (mem_size_in)
            2'h0:    return a & qpf_pkg::TOP_2K;
            2'h1:    return a & qpf_pkg::TOP_4K;
            default: return a & qpf_pkg::TOP_8K;
        endcase
    endfunction : mask
    // word the program memory holds at a wrapped address
    function automatic logic [13:0] word_at(input logic [12:0] a);
        return {1'b1, mask(a) ^ 13'h0A5C};
    endfunction : word_at
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    // random redirects, with corner targets near each variant top;
    // drawn in the seeded initial process so the run repeats
    task automatic drive_random;
        case ($urandom % 5)
            0:       branch_target_in <= qpf_pkg::TOP_2K;
            1:       branch_target_in <= qpf_pkg::TOP_4K;
            2:       branch_target_in <= qpf_pkg::TOP_8K;
            default: branch_target_in <= 13'($urandom);
        endcase
        branch_in <= ($urandom % 4) == 0;
        irq_in    <= ($urandom % 9) == 0;
    endtask : drive_random
    always @(posedge clk_in) begin
        ticks++;
        if (ticks > 6000) begin
            bad_count++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // monitor on the falling edge, where every output has settled
    always @(negedge clk_in) begin
        ph = {ph4, ph3, ph2, ph1};
        if (srst_in) begin
            cyc = 0;
            flush = 1'b0;
            prev_ph = 4'h0;
            rel = 0;
        end else begin
            // idle for the reset edge, then phase one, then rotation
            exp_ph = (prev_ph != 4'h0) ? {prev_ph[2:0], prev_ph[3]} :
                     (rel == 0) ? 4'h0 : 4'h1;
            check(14'(ph), 14'(exp_ph));
            prev_ph = ph;
            rel++;
            check(14'(rd), 14'(ph2 & exec_v));
            check(14'(wr), 14'(ph4 & exec_v));
            if (ph2 && (cyc == 0 || flush))
                check(14'(exec_v), 14'h0000);
            if (ph2 && cyc > 0 && !flush) begin
                check(14'(exec_v), 14'h0001);
                check(instruction_latch_out, word_at(last));
            end
            if (ph3) begin
                // last is the unmasked fetch address, as the counter holds it
                last = (cyc == 0) ? qpf_pkg::RESET_VEC :
                       flush ? tgt : last + 13'h0001;
                exp_addr = mask(last);
                exp_pc   = last + 13'h0001;
                check(14'(prog_addr_out), 14'(exp_addr));
                check(14'(program_counter_out), 14'(exp_pc));
                flush = exec_v && (irq_in || branch_in);
                tgt   = irq_in ? qpf_pkg::IRQ_VEC : branch_target_in;
                cyc++;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        srst_in = 1'b1;
        branch_in = 1'b0;
        irq_in = 1'b0;
        branch_target_in = 13'h0000;
        mem_size_in = 2'h0;
        bad_count = 0;
        n_checks = 0;
        ticks = 0;
        void'($urandom(46719));
        // every variant code, including the unused one, from a fresh reset
        for (int sz = 0; sz < 4; sz++) begin
            @(posedge clk_in);
            srst_in     <= 1'b1;
            mem_size_in <= 2'(sz);
            repeat (2) @(posedge clk_in);
            srst_in <= 1'b0;
            repeat (1200) begin
                @(posedge clk_in);
                drive_random();
            end
        end
        give_verdict();
    end
endmodule : tb

/* File: inc/qpf_pkg.sv */
// shared constants and types of the quad phase fetch pipeline
package qpf_pkg;
    localparam int          PC_W        = 13;
    localparam int          WORD_W      = 14;
    localparam logic [12:0] RESET_VEC   = 13'h0000;
    localparam logic [12:0] IRQ_VEC     = 13'h0004;
    localparam logic [12:0] TOP_2K      = 13'h07FF;
    localparam logic [12:0] TOP_4K      = 13'h0FFF;
    localparam logic [12:0] TOP_8K      = 13'h1FFF;
    localparam logic [1:0]  SIZE_2K     = 2'h0;
    localparam logic [1:0]  SIZE_4K     = 2'h1;
    localparam logic [1:0]  SIZE_8K     = 2'h2;
    localparam logic [13:0] NOP_WORD    = 14'h0000;
    localparam int          PHASES      = 4;
    // phase order gray coded: one bit changes per oscillator edge
    typedef enum logic [1:0] {
        QPF_PH1 = 2'b00,
        QPF_PH2 = 2'b01,
        QPF_PH3 = 2'b11,
        QPF_PH4 = 2'b10
    } qpf_phase_e;
endpackage : qpf_pkg

/* File: src/qpf_core.sv */
// fetch and execute pipeline sequencer with four phase instruction cycle
`timescale 1ns/1ps
module qpf_core (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // variant size select, 0 2K, 1 4K, 2 8K
    input  wire logic [1:0]  mem_size_in,
    // program memory
    input  wire logic [13:0] prog_data_in,
    output logic [12:0]      prog_addr_out,
    // branch and interrupt requests from the execute unit
    input  wire logic        branch_in,
    input  wire logic [12:0] branch_target_in,
    input  wire logic        irq_in,
    // phase clocks
    output logic             phase_one_clock_out,
    output logic             phase_two_clock_out,
    output logic             phase_three_clock_out,
    output logic             phase_four_clock_out,
    // execute stage
    output logic [13:0]      instruction_latch_out,
    output logic             exec_valid_out,
    output logic             data_read_out,
    output logic             data_write_out,
    output logic [12:0]      program_counter_out
);
    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [12:0] pc;
        logic [12:0] addr;
        logic [13:0] fetched;
        logic        fetched_ok;
        logic [13:0] latch;
        logic        exec_ok;
        logic        flush;
        logic        rd;
        logic        wr;
        logic [3:0]  ph;
    } qpf_core_s;

    qpf_core_s  st;
    qpf_core_s  next_st;
    logic [3:0] phase;
    logic [12:0] top;

    qpf_phase_gen u_phase (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .phase_out (phase)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        case (mem_size_in)
            qpf_pkg::SIZE_2K: top = qpf_pkg::TOP_2K;
            qpf_pkg::SIZE_4K: top = qpf_pkg::TOP_4K;
            default:          top = qpf_pkg::TOP_8K;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.ph = phase;
        // phase strobes issued one edge after the phase generator
        next_st.rd = phase[1] && st.exec_ok;
        next_st.wr = phase[3] && st.exec_ok;
        if (phase[0]) begin
            // fetch cycle opens: advance counter
            next_st.addr = st.pc & top;
            next_st.pc   = st.pc + 13'h0001;
            // execute cycle opens: latch previous fetch
            next_st.latch   = st.fetched;
            next_st.exec_ok = st.fetched_ok && !st.flush;
            next_st.flush   = 1'b0;
        end
        if (phase[3]) begin
            next_st.fetched    = prog_data_in;
            next_st.fetched_ok = 1'b1;
            // a taken change of flow discards this fetch
            if (st.exec_ok && irq_in) begin
                next_st.pc    = qpf_pkg::IRQ_VEC;
                next_st.flush = 1'b1;
            end else if (st.exec_ok && branch_in) begin
                next_st.pc    = branch_target_in;
                next_st.flush = 1'b1;
            end
        end
        if (srst_in) begin
            next_st.pc         = qpf_pkg::RESET_VEC;
            next_st.addr       = qpf_pkg::RESET_VEC;
            next_st.fetched    = qpf_pkg::NOP_WORD;
            next_st.fetched_ok = 1'b0;
            next_st.latch      = qpf_pkg::NOP_WORD;
            next_st.exec_ok    = 1'b0;
            next_st.flush      = 1'b0;
            next_st.rd         = 1'b0;
            next_st.wr         = 1'b0;
            next_st.ph         = 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////
    assign prog_addr_out         = st.addr;
    assign phase_one_clock_out   = st.ph[0];
    assign phase_two_clock_out   = st.ph[1];
    assign phase_three_clock_out = st.ph[2];
    assign phase_four_clock_out  = st.ph[3];
    assign instruction_latch_out = st.latch;
    assign exec_valid_out        = st.exec_ok;
    assign data_read_out         = st.rd;
    assign data_write_out        = st.wr;
    assign program_counter_out   = st.pc;

    ////////////////////////////////////////////////////////////////////
    property p_pc_inc;
        @(posedge clk_in) disable iff (srst_in)
            // at the release edge the state is still the reset one
            (!srst_in && phase[0]) |=> st.pc == $past(st.pc) + 13'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc)
        else $error("counter not advanced in phase one");

    property p_fetch_cap;
        @(posedge clk_in) disable iff (srst_in)
            phase[3] |=> st.fetched == $past(prog_data_in);
    endproperty
    a_fetch_cap: assert property (p_fetch_cap)
        else $error("fetch not captured in phase four");

    property p_latch;
        @(posedge clk_in) disable iff (srst_in)
            phase[0] |=> st.latch == $past(st.fetched);
    endproperty
    a_latch: assert property (p_latch)
        else $error("instruction latch not loaded");

    property p_rd_wr;
        @(posedge clk_in) disable iff (srst_in)
            data_read_out |-> ##2 (data_write_out && phase_four_clock_out);
    endproperty
    a_rd_wr: assert property (p_rd_wr)
        else $error("write not two phases after read");

    property p_steady;
        @(posedge clk_in) disable iff (srst_in)
            (phase[0] && st.fetched_ok && !st.flush && !st.exec_ok)
            |=> st.exec_ok;
    endproperty
    a_steady: assert property (p_steady)
        else $error("pipeline did not issue");

    property p_flush;
        @(posedge clk_in) disable iff (srst_in)
            (phase[0] && st.flush) |=> !st.exec_ok;
    endproperty
    a_flush: assert property (p_flush)
        else $error("flushed word executed");

    property p_wrap;
        @(posedge clk_in) disable iff (srst_in)
            prog_addr_out <= top || $changed(mem_size_in);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address beyond implemented memory");

    property p_irq_vec;
        @(posedge clk_in) disable iff (srst_in)
            (phase[3] && st.exec_ok && irq_in)
            |=> st.pc == qpf_pkg::IRQ_VEC;
    endproperty
    a_irq_vec: assert property (p_irq_vec)
        else $error("interrupt vector wrong");

    property p_first;
        @(posedge clk_in) $fell(srst_in) |-> !st.exec_ok [*5];
    endproperty
    a_first: assert property (p_first)
        else $error("executed during first cycle");

    property p_pc8;
        @(posedge clk_in) disable iff (srst_in)
            (phase[0] && st.pc == 13'h1FFF) |=> st.pc == 13'h0000;
    endproperty
    a_pc8: assert property (p_pc8)
        else $error("counter not thirteen bits");

    property p_strobe_phase;
        @(posedge clk_in) disable iff (srst_in)
            (data_read_out |-> phase_two_clock_out)
            and (data_write_out |-> phase_four_clock_out);
    endproperty
    a_strobe_phase: assert property (p_strobe_phase)
        else $error("data strobe outside its phase");

    property p_branch_tgt;
        @(posedge clk_in) disable iff (srst_in)
            (phase[3] && st.exec_ok && branch_in && !irq_in)
            |=> st.pc == $past(branch_target_in);
    endproperty
    a_branch_tgt: assert property (p_branch_tgt)
        else $error("branch target not loaded");

    property p_reset_vec;
        @(posedge clk_in)
            $fell(srst_in) |=> prog_addr_out == qpf_pkg::RESET_VEC;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("first fetch not from reset vector");

    c_exec:   cover property (@(posedge clk_in) st.exec_ok && st.wr);
    c_branch: cover property (@(posedge clk_in) st.flush && phase[0]);
    c_irq:    cover property (@(posedge clk_in) st.pc == 13'h0004);
    c_wrap:   cover property (@(posedge clk_in)
                  st.addr == 13'h07FF && mem_size_in == 2'h0);
endmodule : qpf_core

/* File: src/qpf_phase_gen.sv */
// four phase generator dividing the oscillator clock by four
`timescale 1ns/1ps
module qpf_phase_gen (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    // phase clocks, one hot
    output logic [3:0]       phase_out
);
    typedef struct packed {
        qpf_pkg::qpf_phase_e ph;
        logic [3:0]          oh;
    } qpf_pg_s;

    qpf_pg_s st;
    qpf_pg_s next_st;

    always_comb begin
        next_st = st;
        case (st.ph)
            qpf_pkg::QPF_PH1: next_st.ph = qpf_pkg::QPF_PH2;
            qpf_pkg::QPF_PH2: next_st.ph = qpf_pkg::QPF_PH3;
            qpf_pkg::QPF_PH3: next_st.ph = qpf_pkg::QPF_PH4;
            qpf_pkg::QPF_PH4: next_st.ph = qpf_pkg::QPF_PH1;
            default:          next_st.ph = qpf_pkg::QPF_PH1;
        endcase
        // exactly one phase per edge, so phases never overlap
        case (next_st.ph)
            qpf_pkg::QPF_PH1: next_st.oh = 4'h1;
            qpf_pkg::QPF_PH2: next_st.oh = 4'h2;
            qpf_pkg::QPF_PH3: next_st.oh = 4'h4;
            default:          next_st.oh = 4'h8;
        endcase
        if (srst_in) begin
            next_st.ph = qpf_pkg::QPF_PH1;
            next_st.oh = 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign phase_out = st.oh;

    property p_phase_onehot;
        @(posedge clk_in) disable iff (srst_in) $onehot(st.oh);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot)
        else $error("phase clocks overlap");

    property p_phase_period;
        @(posedge clk_in) disable iff (srst_in)
            // sampled reset keeps the release edge out of the antecedent
            (!srst_in && st.oh[0]) |=> !st.oh[0] [*3] ##1 st.oh[0];
    endproperty
    a_phase_period: assert property (p_phase_period)
        else $error("phase one not every fourth edge");
endmodule : qpf_phase_gen
